// file: rtl/owpc_cfg_mem.sv
// Purpose : holds the twenty port configuration words, one write port and
//           two registered read ports
// Assumes : write and read on the same edge return the old word
// Notes   : each word resets to its own default
`timescale 1ns/100ps
module owpc_cfg_mem #(
  parameter int DEPTH = owpc_pkg::NUM_REGS,
  parameter int AW    = owpc_pkg::REG_AW
) (
  input  wire logic          clk,      // system clock
  input  wire logic          rstn,     // async reset, active low
  input  wire logic          we,       // write enable
  input  wire logic [AW-1:0] waddr,    // write word number
  input  wire logic [15:0]   wdata,    // write data
  input  wire logic [AW-1:0] raddr_a,  // readback port address
  output logic      [15:0]   rdata_a,  // readback port data
  input  wire logic [AW-1:0] raddr_b,  // waveform lookup address
  output logic      [15:0]   rdata_b   // waveform lookup data
);

  if (DEPTH > (1 << AW)) begin : g_bad_depth
    $error("owpc_cfg_mem: DEPTH does not fit the address width");
  end

  logic [15:0] mem_q [DEPTH];
  logic [15:0] mem_d [DEPTH];
  logic [15:0] rdata_a_d;
  logic [15:0] rdata_b_d;

  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      mem_d[i] = (we && (waddr == AW'(i))) ? wdata : mem_q[i];
    end
    rdata_a_d = (int'(raddr_a) < DEPTH) ? mem_q[raddr_a] : 16'h0000;
    rdata_b_d = (int'(raddr_b) < DEPTH) ? mem_q[raddr_b] : 16'h0000;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= owpc_pkg::reg_default(5'(i));
      end
      rdata_a <= 16'h0000;
      rdata_b <= 16'h0000;
    end else begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= mem_d[i];
      end
      rdata_a <= rdata_a_d;
      rdata_b <= rdata_b_d;
    end
  end

endmodule : owpc_cfg_mem

// file: rtl/owpc_pkg.sv
// Purpose : shared constants, types and helpers for the port configuration
//           command block and its register memory
// Assumes : one 40 MHz clock, byte-wide command stream from a serial front end
// Notes   : all register numbers, field positions and reset values live here
package owpc_pkg;

  // ----------------------------------------------------------------------
  // command stream
  // ----------------------------------------------------------------------
  localparam logic [7:0] OP_READ_CFG   = 8'h52;
  localparam logic [7:0] OP_WRITE_CFG  = 8'h99;
  localparam logic [7:0] RES_OK        = 8'hAA;
  localparam logic [7:0] RES_BAD_PARAM = 8'h77;
  localparam logic [7:0] RES_IDLE_FILL = 8'hFF;
  localparam logic [7:0] LEN_READ_REQ  = 8'h01;
  localparam logic [7:0] LEN_WRITE_REQ = 8'h03;
  localparam logic [7:0] RSP_LEN_ONE   = 8'h03;
  localparam logic [7:0] RSP_LEN_ALL   = 8'h29;
  localparam logic [7:0] RSP_LEN_WRITE = 8'h01;
  localparam logic [7:0] SEL_MAX       = 8'h13;
  localparam logic [2:0] BYTES_READ    = 3'h3;
  localparam logic [2:0] BYTES_WRITE   = 3'h5;
  localparam logic [5:0] RSP_DATA_BASE = 6'h02;

  // ----------------------------------------------------------------------
  // register numbers
  // ----------------------------------------------------------------------
  localparam int         NUM_REGS         = 20;
  localparam int         REG_AW           = 5;
  localparam logic [4:0] REG_MASTER_CFG   = 5'h00;
  localparam logic [4:0] REG_STD_BASE     = 5'h01;
  localparam logic [4:0] REG_STD_LAST     = 5'h08;
  localparam logic [4:0] REG_OD_BASE      = 5'h09;
  localparam logic [4:0] REG_OD_LAST      = 5'h10;
  localparam logic [4:0] REG_PULLUP_BUF   = 5'h11;
  localparam logic [4:0] REG_PULLDN_SLEW  = 5'h12;
  localparam logic [4:0] REG_RESERVED     = 5'h13;
  localparam int         SEL_REG_LSB      = 0;
  localparam int         SEL_REG_MSB      = 5;

  // ----------------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------------
  localparam int BIT_SPEED   = 15;
  localparam int BIT_PDN     = 14;
  localparam int BIT_SPU     = 13;
  localparam int BIT_APU     = 12;
  localparam int BIT_CUSTOM  = 15;
  localparam int VALUE_W     = 14;
  localparam int PREDEF_W    = 4;
  localparam logic [15:0] DEF_MASTER  = 16'h0000;
  localparam logic [15:0] DEF_TIMING  = 16'h0006;
  localparam logic [15:0] DEF_PULLUP  = 16'h803C;
  localparam logic [15:0] DEF_SLEW    = 16'h0006;
  localparam logic [15:0] DEF_RSVD    = 16'h5828;

  // custom timing tick, in picoseconds (62.5 ns)
  localparam int TICK_PS       = 62500;
  localparam int CLK_PERIOD_PS = 25000;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_COLLECT = 2'b00,
    ST_EXEC    = 2'b01,
    ST_RESP    = 2'b10
  } owpc_state_t;

  typedef struct packed {
    logic bus_speed_select;
    logic port_power_down;
    logic strong_pullup_en;
    logic active_pullup_en;
  } owpc_master_t;

  typedef struct packed {
    logic                 custom;
    logic [VALUE_W-1:0]   value;
  } owpc_timing_t;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [15:0] reg_default(input logic [4:0] idx);
    if (idx == REG_MASTER_CFG)       return DEF_MASTER;
    else if (idx == REG_PULLUP_BUF)  return DEF_PULLUP;
    else if (idx == REG_PULLDN_SLEW) return DEF_SLEW;
    else if (idx == REG_RESERVED)    return DEF_RSVD;
    else                             return DEF_TIMING;
  endfunction : reg_default

  // predefined entries keep only the table index in the low bits
  function automatic owpc_timing_t timing_decode(input logic [15:0] w);
    owpc_timing_t t;
    t.custom = w[BIT_CUSTOM];
    if (w[BIT_CUSTOM]) t.value = w[VALUE_W-1:0];
    else               t.value = {{(VALUE_W-PREDEF_W){1'b0}}, w[PREDEF_W-1:0]};
    return t;
  endfunction : timing_decode

  function automatic owpc_master_t master_fields(input logic [15:0] w);
    owpc_master_t m;
    m.bus_speed_select = w[BIT_SPEED];
    m.port_power_down  = w[BIT_PDN];
    m.strong_pullup_en = w[BIT_SPU];
    m.active_pullup_en = w[BIT_APU];
    return m;
  endfunction : master_fields

endpackage : owpc_pkg

// file: rtl/owpc_port_cfg.sv
// Purpose : interprets the read and write port configuration commands and
//           drives the bus master controls from the stored configuration
// Assumes : a serial front end delivers written bytes, stops and read strobes
// Notes   : readback data follows a read strobe by three clocks
`timescale 1ns/100ps

// Overview of operation
// RL1 - read command: opcode, length one, selector; answer length 3 or 41, result, data
// RL2 - selector up to 13h returns one register; larger returns all twenty
// RL3 - readback words use the write value layout, low byte first
// RL4 - host writes opcode 99h, selector, then two value bytes low first
// RL5 - write declares length three; answer is length one then result
// RL6 - write checks selector, stores value, answers AAh or 77h
// RL7 - write selector register number in low six bits, valid 0 to 13h
// RL8 - register 0 master, 1-8h standard, 9-10h overdrive, 11h pullup, 12h slew
// RL9 - host never writes reserved register 13h
// RL10 - master bit 12 selects active pullup, reset value zero
// RL11 - active pullup never used on recovery after a line short
// RL12 - host is advised to enable the active pullup
// RL13 - master bit 13 arms strong pullup before byte and bit commands
// RL14 - master bit 14 powers the port down and blocks communication
// RL15 - master bit 15 picks standard or overdrive speed, reset standard
// RL16 - timing bit 15 picks 14-bit tick count or 4-bit table index
// RL17 - host should avoid custom timings shorter than the predefined ones
// RL18 - waveform timing comes from the bank matching the current speed
module owpc_port_cfg #(
  parameter int OP_TIME_NS = 1000
) (
  input  wire logic                   clk,                 // 40 MHz clock
  input  wire logic                   rstn,                // async reset, active low
  input  wire logic                   wr_strb,             // one written byte
  input  wire logic [7:0]             wr_byte,             // written byte value
  input  wire logic                   wr_stop,             // end of write frame
  input  wire logic                   rd_start,            // start of read frame
  input  wire logic                   rd_strb,             // host took rd_byte
  output logic      [7:0]             rd_byte,             // byte offered to host
  output logic                        busy,                // command executing
  input  wire logic                   short_recovery,      // recovering from short
  input  wire logic                   data_cmd_pending,    // byte or bit command next
  input  wire logic [2:0]             timing_sel,          // timing slot 0..7
  output owpc_pkg::owpc_timing_t      timing,              // decoded timing word
  output logic                        active_pullup_en,    // drive active pullup
  output logic                        strong_pullup_en,    // drive strong pullup
  output logic                        port_power_down,     // port unpowered
  output logic                        bus_blocked,         // no bus traffic allowed
  output logic                        bus_speed_select,    // 1 = overdrive
  output logic      [15:0]            pullup_buffer_select,// pullup setting word
  output logic      [15:0]            pulldown_slew_select // slew setting word
);

  localparam int OP_CYCLES_RAW = (OP_TIME_NS * 1000 + owpc_pkg::CLK_PERIOD_PS - 1)
                                 / owpc_pkg::CLK_PERIOD_PS;
  localparam int OP_CYCLES     = (OP_CYCLES_RAW < 1) ? 1 : OP_CYCLES_RAW;

  if (OP_TIME_NS < 1 || OP_CYCLES > 65535) begin : g_bad_op_time
    $error("owpc_port_cfg: OP_TIME_NS out of range");
  end

  // ----------------------------------------------------------------------
  // command collection and sequencing state
  // ----------------------------------------------------------------------
  owpc_pkg::owpc_state_t state_q, state_d;
  logic [2:0]  bcnt_q,    bcnt_d;
  logic [7:0]  op_q,      op_d;
  logic [7:0]  len_q,     len_d;
  logic [7:0]  par0_q,    par0_d;
  logic [7:0]  par1_q,    par1_d;
  logic [7:0]  par2_q,    par2_d;
  logic [15:0] wait_q,    wait_d;
  logic [7:0]  rsp_len_q, rsp_len_d;
  logic [7:0]  result_q,  result_d;
  logic [4:0]  rsel_q,    rsel_d;
  logic        rall_q,    rall_d;
  logic [5:0]  ptr_q,     ptr_d;
  logic        mem_we;
  logic [4:0]  mem_waddr;
  logic [15:0] mem_wdata;
  logic        rd_ok, wr_ok;

  // ----------------------------------------------------------------------
  // shadow copies that feed the line controls
  // ----------------------------------------------------------------------
  logic [15:0] master_q, master_d;
  logic [15:0] pullup_q, pullup_d;
  logic [15:0] slew_q,   slew_d;
  owpc_pkg::owpc_master_t mcfg;

  // ----------------------------------------------------------------------
  // readback and lookup paths
  // ----------------------------------------------------------------------
  logic [15:0] rdata_a, rdata_b;
  logic [4:0]  raddr_a, raddr_b;
  logic [5:0]  data_idx;
  logic [7:0]  rd_byte_d;
  owpc_pkg::owpc_timing_t timing_d;
  logic        apu_d, spu_d;

  always_comb begin
    state_d   = state_q;
    bcnt_d    = bcnt_q;
    op_d      = op_q;
    len_d     = len_q;
    par0_d    = par0_q;
    par1_d    = par1_q;
    par2_d    = par2_q;
    wait_d    = wait_q;
    rsp_len_d = rsp_len_q;
    result_d  = result_q;
    rsel_d    = rsel_q;
    rall_d    = rall_q;
    ptr_d     = ptr_q;
    master_d  = master_q;
    pullup_d  = pullup_q;
    slew_d    = slew_q;
    mem_we    = 1'b0;
    mem_waddr = par0_q[4:0];
    mem_wdata = {par2_q, par1_q};
    // RL1 read frame shape
    rd_ok = (op_q == owpc_pkg::OP_READ_CFG) && (len_q == owpc_pkg::LEN_READ_REQ)
            && (bcnt_q == owpc_pkg::BYTES_READ);
    // RL7 selector range check
    wr_ok = (op_q == owpc_pkg::OP_WRITE_CFG) && (len_q == owpc_pkg::LEN_WRITE_REQ)
            && (bcnt_q == owpc_pkg::BYTES_WRITE)
            && (par0_q[7:owpc_pkg::SEL_REG_MSB+1] == 2'b00)
            && ({2'b00, par0_q[owpc_pkg::SEL_REG_MSB:owpc_pkg::SEL_REG_LSB]}
                <= owpc_pkg::SEL_MAX);

    unique case (state_q)
      owpc_pkg::ST_COLLECT, owpc_pkg::ST_RESP: begin
        if (wr_strb) begin
          unique case (bcnt_q)
            3'h0:    op_d   = wr_byte;
            3'h1:    len_d  = wr_byte;
            3'h2:    par0_d = wr_byte;
            3'h3:    par1_d = wr_byte;
            3'h4:    par2_d = wr_byte;
            default: ;
          endcase
          // extra bytes only saturate the count, which fails the shape checks
          if (bcnt_q != 3'h7) bcnt_d = bcnt_q + 3'h1;
        end
        if (wr_stop && bcnt_q != 3'h0) begin
          state_d = owpc_pkg::ST_EXEC;
          wait_d  = 16'(OP_CYCLES - 1);
          bcnt_d  = 3'h0;
          ptr_d   = 6'h00;
          if (rd_ok) begin
            // RL2 single or full readback
            rall_d    = (par0_q > owpc_pkg::SEL_MAX);
            rsel_d    = par0_q[4:0];
            rsp_len_d = (par0_q > owpc_pkg::SEL_MAX) ? owpc_pkg::RSP_LEN_ALL
                                                     : owpc_pkg::RSP_LEN_ONE;
            result_d  = owpc_pkg::RES_OK;
          end else if (wr_ok) begin
            // RL4 value assembled low byte first
            // RL6 store and report success
            mem_we    = 1'b1;
            rsp_len_d = owpc_pkg::RSP_LEN_WRITE;
            result_d  = owpc_pkg::RES_OK;
            // RL8 mirror of the line control words
            if (par0_q[4:0] == owpc_pkg::REG_MASTER_CFG)  master_d = mem_wdata;
            if (par0_q[4:0] == owpc_pkg::REG_PULLUP_BUF)  pullup_d = mem_wdata;
            if (par0_q[4:0] == owpc_pkg::REG_PULLDN_SLEW) slew_d   = mem_wdata;
          end else begin
            // RL6 bad parameter answer
            // RL5 one byte answer
            rsp_len_d = owpc_pkg::RSP_LEN_WRITE;
            result_d  = owpc_pkg::RES_BAD_PARAM;
          end
        end else if (state_q == owpc_pkg::ST_RESP) begin
          if (rd_start) begin
            ptr_d = 6'h00;
          end else if (rd_strb && ({2'b00, ptr_q} <= rsp_len_q)) begin
            ptr_d = ptr_q + 6'h01;
          end
        end
      end
      owpc_pkg::ST_EXEC: begin
        // bytes and stops during the operation time are dropped
        if (wait_q == 16'h0000) state_d = owpc_pkg::ST_RESP;
        else                    wait_d  = wait_q - 16'h0001;
      end
      default: state_d = owpc_pkg::ST_COLLECT;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q   <= owpc_pkg::ST_COLLECT;
      bcnt_q    <= 3'h0;
      op_q      <= 8'h00;
      len_q     <= 8'h00;
      par0_q    <= 8'h00;
      par1_q    <= 8'h00;
      par2_q    <= 8'h00;
      wait_q    <= 16'h0000;
      rsp_len_q <= owpc_pkg::RSP_LEN_WRITE;
      result_q  <= owpc_pkg::RES_IDLE_FILL;
      rsel_q    <= 5'h00;
      rall_q    <= 1'b0;
      ptr_q     <= 6'h00;
      // RL10 RL15 master word resets to zero
      master_q  <= owpc_pkg::DEF_MASTER;
      pullup_q  <= owpc_pkg::DEF_PULLUP;
      slew_q    <= owpc_pkg::DEF_SLEW;
    end else begin
      state_q   <= state_d;
      bcnt_q    <= bcnt_d;
      op_q      <= op_d;
      len_q     <= len_d;
      par0_q    <= par0_d;
      par1_q    <= par1_d;
      par2_q    <= par2_d;
      wait_q    <= wait_d;
      rsp_len_q <= rsp_len_d;
      result_q  <= result_d;
      rsel_q    <= rsel_d;
      rall_q    <= rall_d;
      ptr_q     <= ptr_d;
      master_q  <= master_d;
      pullup_q  <= pullup_d;
      slew_q    <= slew_d;
    end
  end

  // ----------------------------------------------------------------------
  // configuration memory
  // ----------------------------------------------------------------------
  owpc_cfg_mem #(
    .DEPTH (owpc_pkg::NUM_REGS),
    .AW    (owpc_pkg::REG_AW)
  ) u_mem (
    .clk     (clk),
    .rstn    (rstn),
    .we      (mem_we),
    .waddr   (mem_waddr),
    .wdata   (mem_wdata),
    .raddr_a (raddr_a),
    .rdata_a (rdata_a),
    .raddr_b (raddr_b),
    .rdata_b (rdata_b)
  );

  // ----------------------------------------------------------------------
  // readback byte and line controls
  // ----------------------------------------------------------------------
  always_comb begin
    mcfg     = owpc_pkg::master_fields(master_q);
    data_idx = ptr_q - owpc_pkg::RSP_DATA_BASE;
    // RL2 full dump walks words in order, two bytes each
    raddr_a  = rall_q ? data_idx[5:1] : rsel_q;
    // RL18 speed bit picks the timing bank
    raddr_b  = (mcfg.bus_speed_select ? owpc_pkg::REG_OD_BASE : owpc_pkg::REG_STD_BASE)
               + {2'b00, timing_sel};
    if (ptr_q == 6'h00) begin
      rd_byte_d = rsp_len_q;
    end else if (ptr_q == 6'h01) begin
      rd_byte_d = result_q;
    end else if ({2'b00, ptr_q} < rsp_len_q + 8'h01) begin
      // RL3 low byte first, same layout as a write value
      rd_byte_d = data_idx[0] ? rdata_a[15:8] : rdata_a[7:0];
    end else begin
      rd_byte_d = owpc_pkg::RES_IDLE_FILL;
    end
    // RL16 custom tick count or table index
    timing_d = owpc_pkg::timing_decode(rdata_b);
    // RL10 RL11 active pullup gated off during short recovery
    apu_d    = mcfg.active_pullup_en && !short_recovery && !mcfg.port_power_down;
    // RL13 strong pullup only ahead of data commands
    spu_d    = mcfg.strong_pullup_en && data_cmd_pending && !mcfg.port_power_down;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_byte              <= owpc_pkg::RSP_LEN_WRITE;
      busy                 <= 1'b0;
      timing               <= owpc_pkg::timing_decode(owpc_pkg::DEF_TIMING);
      active_pullup_en     <= 1'b0;
      strong_pullup_en     <= 1'b0;
      port_power_down      <= 1'b0;
      bus_blocked          <= 1'b0;
      bus_speed_select     <= 1'b0;
      pullup_buffer_select <= owpc_pkg::DEF_PULLUP;
      pulldown_slew_select <= owpc_pkg::DEF_SLEW;
    end else begin
      rd_byte              <= rd_byte_d;
      busy                 <= (state_d == owpc_pkg::ST_EXEC);
      timing               <= timing_d;
      active_pullup_en     <= apu_d;
      strong_pullup_en     <= spu_d;
      // RL14 power down blocks the bus
      port_power_down      <= mcfg.port_power_down;
      bus_blocked          <= mcfg.port_power_down;
      // RL15 speed bit straight to the waveform side
      bus_speed_select     <= mcfg.bus_speed_select;
      pullup_buffer_select <= pullup_q;
      pulldown_slew_select <= slew_q;
    end
  end

endmodule : owpc_port_cfg

// file: sim/owpc_host_model.sv
// Purpose: host side of the command byte stream
// Assumes: drives on falling edges
// Notes  : released byte lines show the inverse of the last value
`timescale 1ns/100ps
module owpc_host_model (
  input  wire logic       clk,      // clock
  input  wire logic       busy,     // executing
  input  wire logic [7:0] rd_byte,  // answer byte
  output logic            wr_strb,  // byte strobe
  output logic      [7:0] wr_byte,  // byte value
  output logic            wr_stop,  // frame end
  output logic            rd_start, // read start
  output logic            rd_strb   // byte taken
);
  initial begin
    wr_strb  = 1'b0;
    wr_byte  = 8'h00;
    wr_stop  = 1'b0;
    rd_start = 1'b0;
    rd_strb  = 1'b0;
  end
  // callers keep off 13h and short custom times
  task automatic send(input logic [7:0] b[$], output bit to);
    int n;
    n = 0;
    foreach (b[i]) begin
      @(negedge clk);
      wr_strb = 1'b1;
      wr_byte = b[i];
    end
    @(negedge clk);
    wr_strb = 1'b0;
    wr_byte = ~wr_byte;
    wr_stop = 1'b1;
    @(negedge clk);
    wr_stop = 1'b0;
    repeat (2) @(negedge clk);
    while (busy && n < 200) begin
      @(negedge clk);
      n++;
    end
    to = busy;
  endtask : send
  // no prefetch in the block, so strobes stay three cycles apart
  task automatic get(input int cnt, output logic [7:0] r[$]);
    r = {};
    @(negedge clk);
    rd_start = 1'b1;
    @(negedge clk);
    rd_start = 1'b0;
    for (int i = 0; i < cnt; i++) begin
      repeat (2) @(negedge clk);
      r.push_back(rd_byte);
      rd_strb = 1'b1;
      @(negedge clk);
      rd_strb = 1'b0;
    end
  endtask : get
endmodule : owpc_host_model

// file: sim/owpc_port_cfg_checker.sv
// Purpose: port assertions for owpc_port_cfg
// Assumes: one clock, rstn async active low
// Notes  : bound below the module
`timescale 1ns/100ps
module owpc_port_cfg_checker #(
  parameter int OP_TIME_NS = 1000
) (
  input wire logic                   clk,                 // clock
  input wire logic                   rstn,                // reset
  input wire logic                   wr_strb,             // byte in
  input wire logic [7:0]             wr_byte,             // byte value
  input wire logic                   wr_stop,             // frame end
  input wire logic                   rd_start,            // read start
  input wire logic                   rd_strb,             // byte taken
  input wire logic [7:0]             rd_byte,             // byte out
  input wire logic                   busy,                // executing
  input wire logic                   short_recovery,      // short
  input wire logic                   data_cmd_pending,    // data cmd
  input wire logic [2:0]             timing_sel,          // slot
  input wire owpc_pkg::owpc_timing_t timing,              // timing
  input wire logic                   active_pullup_en,    // apu
  input wire logic                   strong_pullup_en,    // spu
  input wire logic                   port_power_down,     // pdn
  input wire logic                   bus_blocked,         // blocked
  input wire logic                   bus_speed_select,    // speed
  input wire logic [15:0]            pullup_buffer_select,// pullup
  input wire logic [15:0]            pulldown_slew_select // slew
);
  // busy lasts the operation time rounded up to whole 25 ns clocks, at least one
  localparam int OP_CYC_RAW = (OP_TIME_NS + 24) / 25;
  localparam int OP_CYC     = (OP_CYC_RAW < 1) ? 1 : OP_CYC_RAW;
  int unsigned cnt_d;
  int unsigned cnt_q;
  always_comb cnt_d = busy ? cnt_q + 1 : 0;
  always_ff @(posedge clk or negedge rstn)
    if (!rstn) cnt_q <= 0;
    else       cnt_q <= cnt_d;
  default clocking dcb @(posedge clk); endclocking
  default disable iff (!rstn);
  AST_BUSY_START: assert property ($rose(busy) |-> $past(wr_stop))
    else $error("busy rose without a stop");
  AST_BUSY_LEN: assert property ($fell(busy) |-> cnt_q == OP_CYC)
    else $error("operation time wrong");
  AST_SHORT_NO_APU: assert property (short_recovery |=> !active_pullup_en)
    else $error("active pullup during short recovery");
  AST_DN_PULLS_OFF: assert property (port_power_down |-> !active_pullup_en && !strong_pullup_en)
    else $error("pullup while powered down");
  AST_DN_BLOCKS: assert property (port_power_down == bus_blocked)
    else $error("power down not blocking");
  AST_SPU_NEEDS_CMD: assert property (!data_cmd_pending |=> !strong_pullup_en)
    else $error("strong pullup without data command");
  AST_SPEED_IN_CMD: assert property ($changed(bus_speed_select) |-> busy)
    else $error("speed changed outside a command");
  AST_SEL_IN_CMD: assert property ($changed(pulldown_slew_select) || $changed(pullup_buffer_select) |-> busy)
    else $error("setting changed outside a command");
  AST_PREDEF_IDX: assert property (!timing.custom |-> timing.value[13:4] == 0)
    else $error("table index wider than four bits");
endmodule : owpc_port_cfg_checker
bind owpc_port_cfg owpc_port_cfg_checker #(.OP_TIME_NS(OP_TIME_NS)) owpc_port_cfg_checker_inst (
  .clk, .rstn, .wr_strb, .wr_byte, .wr_stop, .rd_start, .rd_strb, .rd_byte, .busy,
  .short_recovery, .data_cmd_pending, .timing_sel, .timing, .active_pullup_en,
  .strong_pullup_en, .port_power_down, .bus_blocked, .bus_speed_select,
  .pullup_buffer_select, .pulldown_slew_select);

// file: sim/owpc_port_cfg_tb_top.sv
// Purpose: command level test of owpc_port_cfg
// Assumes: short operation time for a quick run
// Notes  : expected words come from the register table
`timescale 1ns/100ps
module owpc_port_cfg_tb_top;
  logic clk = 1'b0;
  logic rstn, wr_strb, wr_stop, rd_start, rd_strb, busy;
  logic short_recovery, data_cmd_pending;
  logic active_pullup_en, strong_pullup_en, port_power_down, bus_blocked;
  logic bus_speed_select;
  logic [7:0] wr_byte, rd_byte;
  logic [2:0] timing_sel;
  logic [15:0] pullup_buffer_select, pulldown_slew_select, dflt[$];
  owpc_pkg::owpc_timing_t timing;
  int n_mismatch, n_compared;

  always #12.5 clk = ~clk;

  owpc_port_cfg #(.OP_TIME_NS(50)) owpc_port_cfg_inst (
    .clk, .rstn, .wr_strb, .wr_byte, .wr_stop, .rd_start, .rd_strb, .rd_byte, .busy,
    .short_recovery, .data_cmd_pending, .timing_sel, .timing, .active_pullup_en,
    .strong_pullup_en, .port_power_down, .bus_blocked, .bus_speed_select,
    .pullup_buffer_select, .pulldown_slew_select);
  owpc_host_model owpc_host_model_inst (
    .clk, .busy, .rd_byte, .wr_strb, .wr_byte, .wr_stop, .rd_start, .rd_strb);

  task automatic test_done();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : test_done
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk16
  task automatic chk_bit(input logic got, input logic exp);
    chk16({15'h0000, got}, {15'h0000, exp});
  endtask : chk_bit
  task automatic xfer(input logic [7:0] b[$], input int cnt, output logic [7:0] r[$]);
    bit to;
    owpc_host_model_inst.send(b, to);
    if (to) begin
      n_mismatch++;
      test_done();
    end
    owpc_host_model_inst.get(cnt, r);
  endtask : xfer
  task automatic wr_reg(input logic [7:0] sel, input logic [15:0] v, input logic [7:0] res);
    logic [7:0] r[$];
    xfer('{8'h99, 8'h03, sel, v[7:0], v[15:8]}, 2, r);
    chk16({8'h00, r[0]}, 16'h0001);
    chk16({8'h00, r[1]}, {8'h00, res});
  endtask : wr_reg
  task automatic rd_chk(input logic [7:0] sel, input logic [15:0] w[$]);
    logic [7:0] r[$];
    xfer('{8'h52, 8'h01, sel}, 2 * w.size() + 2, r);
    chk16({8'h00, r[0]}, 16'(2 * w.size() + 1));
    chk16({8'h00, r[1]}, 16'h00AA);
    foreach (w[i]) chk16({r[2*i+3], r[2*i+2]}, w[i]);
  endtask : rd_chk

  initial begin
    rstn = 1'b0;
    short_recovery = 1'b0;
    data_cmd_pending = 1'b0;
    timing_sel = 3'h0;
    for (int i = 0; i < 20; i++)
      dflt.push_back(i == 0 ? 16'h0000 : i == 17 ? 16'h803C : i == 19 ? 16'h5828 : 16'h0006);
    repeat (6) @(negedge clk);
    rstn = 1'b1;
    repeat (3) @(negedge clk);
    chk_bit(bus_speed_select, 1'b0);
    chk_bit(active_pullup_en, 1'b0);
    chk16(pullup_buffer_select, 16'h803C);
    rd_chk(8'hFF, dflt);
    rd_chk(8'h14, dflt);
    rd_chk(8'h13, '{16'h5828});
    wr_reg(8'h09, 16'h8300, 8'hAA);
    wr_reg(8'h01, 16'h00F7, 8'hAA);
    chk16({timing.custom, 1'b0, timing.value}, 16'h0007);
    wr_reg(8'h00, 16'h9000, 8'hAA);
    chk_bit(bus_speed_select, 1'b1);
    chk_bit(active_pullup_en, 1'b1);
    chk16({timing.custom, 1'b0, timing.value}, 16'h8300);
    short_recovery = 1'b1;
    repeat (2) @(negedge clk);
    chk_bit(active_pullup_en, 1'b0);
    short_recovery = 1'b0;
    data_cmd_pending = 1'b1;
    wr_reg(8'h00, 16'h2000, 8'hAA);
    chk_bit(strong_pullup_en, 1'b1);
    chk_bit(bus_speed_select, 1'b0);
    timing_sel = 3'h7;
    wr_reg(8'h00, 16'h7000, 8'hAA);
    chk_bit(bus_blocked, 1'b1);
    chk_bit(strong_pullup_en, 1'b0);
    chk16({timing.custom, 1'b0, timing.value}, 16'h0006);
    wr_reg(8'h00, 16'h0000, 8'hAA);
    chk_bit(port_power_down, 1'b0);
    data_cmd_pending = 1'b0;
    wr_reg(8'h14, 16'h1234, 8'h77);
    wr_reg(8'h40, 16'h1234, 8'h77);
    rd_chk(8'h00, '{16'h0000});
    wr_reg(8'h12, 16'h0009, 8'hAA);
    chk16(pulldown_slew_select, 16'h0009);
    rd_chk(8'h11, '{16'h803C});
    test_done();
  end
endmodule : owpc_port_cfg_tb_top
